// file: rtl/sleds_pkg.sv
// Summary of operation
// - Run LED lit while executing with key in run or step-run.
// - Run LED off when halted by stop, pause, or stop error.
// - Run LED flickers after stop-time program write until run-stop-run or reset.
// - Error LED lit for continue error other than battery in resume mode.
// - Error LED flickers on stop error; off when normal.
// - User LED lit on check instruction or annunciator; flickers during latch clear.
// - Battery alarm LED lit on low battery in module or memory card.
// - Boot LED lit once boot has completed; off if no boot ran.
// - LED clear instruction turns off error, user, battery LEDs, not boot.
// - Error reset trigger rising edge resets the coded continue error, not boot.
// - LED-off trigger rising edge turns off selected user (10h) and boot (100h) LEDs.
// - Select bit one turns that LED off; zero leaves boot unchanged and lets the user LED light again.
// - A stop error is always indicated, regardless of priority settings.
// - Continue errors are indicated by the item order in three priority registers.
// - Among equal priority errors the first detected is indicated.
// - Default order 1,2,3,4,5,6,7,8,9,A.
// - An item removed from the priority registers never lights an LED.
// - Suppressed errors still set both error flags and store the code.
// - Constant scan starts scans at a fixed period; zero setting disables it.
// - A scan over the constant period records code 5010 and runs unpaced.
// - Constant scan above watchdog time raises watchdog error and stops execution.
// - During the wait the main program is held; interrupts and low-speed run.
// - A running low-speed instruction extends the scan until it finishes.
// - Error reset ignores the last two digits of the supplied code.
package sleds_pkg;

    localparam logic [7:0]  ADDR_ERR_RESET_CODE = 8'h00;
    localparam logic [7:0]  ADDR_LED_OFF_SELECT = 8'h04;
    localparam logic [7:0]  ADDR_PRIO_LOW       = 8'h08;
    localparam logic [7:0]  ADDR_PRIO_MID       = 8'h0c;
    localparam logic [7:0]  ADDR_PRIO_HIGH      = 8'h10;
    localparam logic [7:0]  ADDR_CONTROL        = 8'h14;
    localparam logic [7:0]  ADDR_CONST_SCAN     = 8'h18;
    localparam logic [7:0]  ADDR_WATCHDOG       = 8'h1c;
    localparam logic [7:0]  ADDR_STATUS         = 8'h20;
    localparam logic [7:0]  ADDR_DIAG_CODE      = 8'h24;

    localparam int          CTRL_ERR_RESET_TRIG = 0;
    localparam int          CTRL_LED_OFF_TRIG   = 1;
    localparam int          CTRL_LED_CLEAR      = 2;
    localparam int          CTRL_RESUME_MODE    = 3;
    localparam int          CTRL_FLAG_CLEAR     = 4;

    localparam int          SEL_USER_BIT        = 4;
    localparam int          SEL_BOOT_BIT        = 8;

    localparam logic [15:0] PRIO_LOW_RESET      = 16'h4321;
    localparam logic [15:0] PRIO_MID_RESET      = 16'h8765;
    localparam logic [15:0] PRIO_HIGH_RESET     = 16'h00a9;
    localparam logic [31:0] CONTROL_RESET       = 32'h0000_0008;

    localparam logic [3:0]  ITEM_SCAN_OVER      = 4'h5;
    localparam logic [3:0]  ITEM_CHECK          = 4'h6;
    localparam logic [3:0]  ITEM_ANNUNC         = 4'h7;
    localparam logic [3:0]  ITEM_BATTERY        = 4'h9;
    localparam int          ITEMS               = 11;
    localparam int          SLOTS               = 12;

    localparam logic [15:0] CODE_SCAN_OVER      = 16'h5010;
    localparam logic [15:0] CODE_WATCHDOG       = 16'h5000;
    localparam logic [15:0] CODE_ITEM_BASE      = 16'h2000;

    localparam int          FLICKER_NS          = 200_000_000;
    localparam int          CLK_NS              = 10;
    localparam int          FLICKER_CYCLES      = FLICKER_NS / CLK_NS;
    localparam int          SCAN_UNIT_NS        = 1_000;
    localparam int          SCAN_UNIT_CYCLES    = SCAN_UNIT_NS / CLK_NS;

    typedef enum logic [1:0] {SLEDS_KEY_STOP, SLEDS_KEY_RUN, SLEDS_KEY_STEP, SLEDS_KEY_PAUSE} sleds_key_e;

    typedef struct packed {
        logic run;
        logic error;
        logic user;
        logic battery;
        logic boot;
    } sleds_led_s;

    typedef enum logic [1:0] {SLEDS_SC_IDLE, SLEDS_SC_RUN, SLEDS_SC_WAIT, SLEDS_SC_EXTEND} sleds_scan_e;

endpackage : sleds_pkg

// file: rtl/sleds_top.sv
`timescale 1ns/1ps
module sleds_top
    import sleds_pkg::*;
#(
    parameter int FLICKER_HALF = FLICKER_CYCLES,
    parameter int SCAN_UNIT    = SCAN_UNIT_CYCLES
) (
    // Clock and reset.
    input  wire logic        CLK,
    input  wire logic        NRST,
    // AHB-Lite slave.
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Panel and diagnostics inputs.
    input  wire logic [1:0]  KEY_SWITCH,
    input  wire logic        PROGRAM_WRITTEN,
    input  wire logic        STOP_ERROR,
    input  wire logic [10:1] CONT_ERROR,
    input  wire logic        LATCH_CLEAR_BUSY,
    input  wire logic        BOOT_DONE,
    input  wire logic        SCAN_DONE,
    input  wire logic        LOW_SPEED_BUSY,
    // Panel and diagnostics outputs.
    output sleds_led_s       LEDS,
    output logic             DIAGNOSTIC_ERROR_FLAG,
    output logic             SELF_DIAGNOSTIC_ERROR_FLAG,
    output logic             SCAN_START,
    output logic             MAIN_HOLD,
    output logic             EXECUTING
);

    logic [1:0]  key_meta, key_sync;
    logic [10:1] cerr_meta, cerr_sync;
    logic [7:0]  misc_meta, misc_sync;
    logic        ap_valid, ap_write;
    logic [7:0]  ap_addr;
    logic [15:0] error_reset_code, led_off_select;
    logic [15:0] prio_low, prio_mid, prio_high;
    logic [31:0] control, const_scan, watchdog;
    logic [15:0] diagnostic_error_code_reg;
    logic [10:1] active, active_d;
    logic [3:0]  shown_item;
    logic        err_trig_d, off_trig_d, clear_d;
    logic        user_off, boot_off, wdt_error, scan_over, ignore_const;
    logic        run_seen, run_seen_stop, flicker_run;
    logic [31:0] flick_cnt, unit_cnt, scan_cnt;
    logic        flick;
    sleds_scan_e scan_state;
    logic [47:0] order;
    logic [10:1] enabled;
    logic        stop_err, boot_in, prog_wr, latch_busy, scan_done, low_busy;

    // External levels are double-registered before any logic reads them.
    always_ff @(posedge CLK) begin
        key_meta  <= KEY_SWITCH;
        key_sync  <= key_meta;
        cerr_meta <= CONT_ERROR;
        cerr_sync <= cerr_meta;
        misc_meta <= {2'h0, STOP_ERROR, BOOT_DONE, PROGRAM_WRITTEN, LATCH_CLEAR_BUSY, SCAN_DONE, LOW_SPEED_BUSY};
        misc_sync <= misc_meta;
    end

    assign stop_err   = misc_sync[5] | wdt_error;
    assign boot_in    = misc_sync[4];
    assign prog_wr    = misc_sync[3];
    assign latch_busy = misc_sync[2];
    assign scan_done  = misc_sync[1];
    assign low_busy   = misc_sync[0];
    assign order      = {prio_high, prio_mid, prio_low};

    // Bus address phase is captured and completed with zero wait states.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= 8'h00;
        end else if (HREADY) begin
            ap_valid <= HSEL & HTRANS[1];
            ap_write <= HWRITE;
            ap_addr  <= HADDR[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    // Read data is registered in the address phase so it stands in the data phase.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            HRDATA <= 32'h0;
        end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
            unique case (HADDR[7:0])
                ADDR_ERR_RESET_CODE: HRDATA <= {16'h0, error_reset_code};
                ADDR_LED_OFF_SELECT: HRDATA <= {16'h0, led_off_select};
                ADDR_PRIO_LOW:       HRDATA <= {16'h0, prio_low};
                ADDR_PRIO_MID:       HRDATA <= {16'h0, prio_mid};
                ADDR_PRIO_HIGH:      HRDATA <= {16'h0, prio_high};
                ADDR_CONTROL:        HRDATA <= control;
                ADDR_CONST_SCAN:     HRDATA <= const_scan;
                ADDR_WATCHDOG:       HRDATA <= watchdog;
                ADDR_STATUS:         HRDATA <= {16'h0, 1'b0, shown_item, ignore_const, wdt_error,
                                                DIAGNOSTIC_ERROR_FLAG, SELF_DIAGNOSTIC_ERROR_FLAG, 2'h0, LEDS};
                ADDR_DIAG_CODE:      HRDATA <= {16'h0, diagnostic_error_code_reg};
                default:             HRDATA <= 32'h0;
            endcase
        end
    end

    // Software writes land in the data phase.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            error_reset_code <= 16'h0;
            led_off_select   <= 16'h0;
            prio_low         <= PRIO_LOW_RESET;
            prio_mid         <= PRIO_MID_RESET;
            prio_high        <= PRIO_HIGH_RESET;
            control          <= CONTROL_RESET;
            const_scan       <= 32'h0;
            watchdog         <= 32'h0;
        end else if (ap_valid && ap_write) begin
            unique case (ap_addr)
                ADDR_ERR_RESET_CODE: error_reset_code <= HWDATA[15:0];
                ADDR_LED_OFF_SELECT: led_off_select   <= HWDATA[15:0];
                ADDR_PRIO_LOW:       prio_low         <= HWDATA[15:0];
                ADDR_PRIO_MID:       prio_mid         <= HWDATA[15:0];
                ADDR_PRIO_HIGH:      prio_high        <= HWDATA[15:0];
                ADDR_CONTROL:        control          <= HWDATA;
                ADDR_CONST_SCAN:     const_scan       <= HWDATA;
                ADDR_WATCHDOG:       watchdog         <= HWDATA;
                default:             control          <= control;
            endcase
        end
    end

    // An item lights nothing unless some slot names it.
    genvar g;
    generate
        for (g = 1; g <= 10; g++) begin : g_item
            logic [SLOTS-1:0] hit;
            for (genvar s = 0; s < SLOTS; s++) begin : g_slot
                assign hit[s] = (order[4*s +: 4] == 4'(g));
            end
            assign enabled[g] = |hit;
        end
    endgenerate

    // Active errors: latched on arrival, dropped by reset code or LED clear once the cause is gone.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            active     <= '0;
            active_d   <= '0;
            err_trig_d <= 1'b0;
            off_trig_d <= 1'b0;
            clear_d    <= 1'b0;
        end else begin
            err_trig_d <= control[CTRL_ERR_RESET_TRIG];
            off_trig_d <= control[CTRL_LED_OFF_TRIG];
            clear_d    <= control[CTRL_LED_CLEAR];
            active_d   <= active;
            for (int i = 1; i <= 10; i++) begin
                if (cerr_sync[i] || (i == 5 && scan_over)) begin
                    active[i] <= 1'b1;
                end else if (control[CTRL_LED_CLEAR] && !clear_d) begin
                    active[i] <= 1'b0;
                end else if (control[CTRL_ERR_RESET_TRIG] && !err_trig_d &&
                             error_reset_code[15:8] == CODE_ITEM_BASE[15:8] + 8'(i)) begin
                    active[i] <= 1'b0;
                end
            end
        end
    end

    // The lowest slot naming an active item wins.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            shown_item <= 4'h0;
        end else begin
            shown_item <= 4'h0;
            for (int s = SLOTS - 1; s >= 0; s--) begin
                if (order[4*s +: 4] != 4'h0 && order[4*s +: 4] <= 4'ha && active[order[4*s +: 4]]) begin
                    shown_item <= order[4*s +: 4];
                end
            end
        end
    end

    // Flags and code are set for every continue error, shown or not.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            DIAGNOSTIC_ERROR_FLAG      <= 1'b0;
            SELF_DIAGNOSTIC_ERROR_FLAG <= 1'b0;
            diagnostic_error_code_reg  <= 16'h0;
        end else begin
            for (int i = 1; i <= 10; i++) begin
                if (active[i] && !active_d[i]) begin
                    diagnostic_error_code_reg <= (i == 5 && ignore_const) ? CODE_SCAN_OVER
                                                 : CODE_ITEM_BASE + {8'(i), 8'h00};
                end
            end
            if (wdt_error) begin
                diagnostic_error_code_reg <= CODE_WATCHDOG;
            end
            if ((active & ~active_d) != '0 || (stop_err && misc_sync[5])) begin
                DIAGNOSTIC_ERROR_FLAG      <= 1'b1;
                SELF_DIAGNOSTIC_ERROR_FLAG <= 1'b1;
            end else if (control[CTRL_FLAG_CLEAR]) begin
                DIAGNOSTIC_ERROR_FLAG      <= 1'b0;
                SELF_DIAGNOSTIC_ERROR_FLAG <= 1'b0;
            end
        end
    end

    // LED-off trigger clears the selected user and boot indications.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            user_off <= 1'b0;
            boot_off <= 1'b0;
        end else if (control[CTRL_LED_OFF_TRIG] && !off_trig_d) begin
            user_off <= led_off_select[SEL_USER_BIT];
            boot_off <= led_off_select[SEL_BOOT_BIT] | boot_off;
        end else if (!(active[ITEM_CHECK] | active[ITEM_ANNUNC])) begin
            user_off <= 1'b0;
        end
    end

    // Flicker time base.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            flick_cnt <= 32'h0;
            flick     <= 1'b0;
        end else if (flick_cnt >= 32'(FLICKER_HALF - 1)) begin
            flick_cnt <= 32'h0;
            flick     <= ~flick;
        end else begin
            flick_cnt <= flick_cnt + 32'h1;
        end
    end

    // Run flicker after a stop-time write; a full run-stop-run cycle cures it.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            flicker_run   <= 1'b0;
            run_seen      <= 1'b0;
            run_seen_stop <= 1'b0;
        end else if (key_sync == SLEDS_KEY_STOP && prog_wr) begin
            flicker_run   <= 1'b1;
            run_seen      <= 1'b0;
            run_seen_stop <= 1'b0;
        end else if (flicker_run && key_sync == SLEDS_KEY_RUN) begin
            run_seen    <= 1'b1;
            flicker_run <= !run_seen_stop;
        end else if (flicker_run && run_seen && key_sync == SLEDS_KEY_STOP) begin
            run_seen_stop <= 1'b1;
        end
    end

    // LED drive. A stop error overrides the priority scheme.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            LEDS      <= '0;
            EXECUTING <= 1'b0;
        end else begin
            EXECUTING <= (key_sync == SLEDS_KEY_RUN || key_sync == SLEDS_KEY_STEP) && !stop_err && !flicker_run;
            if (stop_err) begin
                LEDS.run <= 1'b0;
            end else if (flicker_run && key_sync == SLEDS_KEY_RUN) begin
                LEDS.run <= flick;
            end else begin
                LEDS.run <= key_sync == SLEDS_KEY_RUN || key_sync == SLEDS_KEY_STEP;
            end
            if (stop_err) begin
                LEDS.error <= flick;
            end else begin
                LEDS.error <= control[CTRL_RESUME_MODE] && shown_item != 4'h0 &&
                              shown_item != ITEM_BATTERY;
            end
            if (latch_busy) begin
                LEDS.user <= flick;
            end else begin
                LEDS.user <= ((active[ITEM_CHECK] && enabled[ITEM_CHECK]) ||
                              (active[ITEM_ANNUNC] && enabled[ITEM_ANNUNC])) && !user_off;
            end
            LEDS.battery <= active[ITEM_BATTERY] && enabled[ITEM_BATTERY];
            LEDS.boot    <= boot_in && !boot_off;
        end
    end

    // Constant scan pacing; the setting counts microsecond units.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            scan_state   <= SLEDS_SC_IDLE;
            unit_cnt     <= 32'h0;
            scan_cnt     <= 32'h0;
            SCAN_START   <= 1'b0;
            MAIN_HOLD    <= 1'b0;
            ignore_const <= 1'b0;
            scan_over    <= 1'b0;
            wdt_error    <= 1'b0;
        end else begin
            SCAN_START <= 1'b0;
            scan_over  <= 1'b0;
            if (const_scan != 32'h0 && watchdog != 32'h0 && const_scan > watchdog) begin
                wdt_error <= 1'b1;
            end
            if (unit_cnt >= 32'(SCAN_UNIT - 1)) begin
                unit_cnt <= 32'h0;
                scan_cnt <= scan_cnt + 32'h1;
            end else begin
                unit_cnt <= unit_cnt + 32'h1;
            end
            unique case (scan_state)
                SLEDS_SC_IDLE: begin
                    MAIN_HOLD <= 1'b0;
                    if (EXECUTING && !wdt_error) begin
                        SCAN_START <= 1'b1;
                        scan_cnt   <= 32'h0;
                        unit_cnt   <= 32'h1;
                        scan_state <= SLEDS_SC_RUN;
                    end
                end
                SLEDS_SC_RUN: begin
                    if (!EXECUTING || wdt_error) begin
                        scan_state <= SLEDS_SC_IDLE;
                    end else if (!ignore_const && const_scan != 32'h0 && scan_cnt >= const_scan) begin
                        scan_over    <= 1'b1;
                        ignore_const <= 1'b1;
                    end else if (scan_done) begin
                        if (const_scan == 32'h0 || ignore_const) begin
                            scan_state <= SLEDS_SC_IDLE;
                        end else begin
                            MAIN_HOLD  <= 1'b1;
                            scan_state <= SLEDS_SC_WAIT;
                        end
                    end
                end
                SLEDS_SC_WAIT: begin
                    if (scan_cnt + 32'(unit_cnt >= 32'(SCAN_UNIT - 1)) >= const_scan) begin
                        scan_state <= low_busy ? SLEDS_SC_EXTEND : SLEDS_SC_IDLE;
                    end
                end
                SLEDS_SC_EXTEND: begin
                    if (!low_busy) begin
                        scan_state <= SLEDS_SC_IDLE;
                    end
                end
            endcase
        end
    end

endmodule : sleds_top

// file: verification/sleds_checker.sv
`timescale 1ns/1ps
module sleds_checker
    import sleds_pkg::*;
#(
    parameter int FLICKER_HALF = 4,
    parameter int SCAN_UNIT    = 2
) (
    // Clock, reset and bus answer.
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    // Panel and diagnostics.
    input wire logic [1:0]  KEY_SWITCH,
    input wire logic        STOP_ERROR,
    input wire logic [10:1] CONT_ERROR,
    input wire logic        BOOT_DONE,
    input wire sleds_led_s  LEDS,
    input wire logic        DIAGNOSTIC_ERROR_FLAG,
    input wire logic        SELF_DIAGNOSTIC_ERROR_FLAG,
    input wire logic        SCAN_START,
    input wire logic        EXECUTING
);
    logic boot_seen;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            boot_seen <= 1'h0;
        end else if (BOOT_DONE) begin
            boot_seen <= 1'h1;
        end
    end
    sequence s_stop_held;
        STOP_ERROR [*8];
    endsequence
    sequence s_key_idle;
        !(KEY_SWITCH inside {2'h1, 2'h2}) [*5];
    endsequence
    sequence s_cont_held;
        (|CONT_ERROR[7:1]) [*5];
    endsequence
    a_ready_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not ready or not okay");
    a_key_idle_dark: assert property (s_key_idle |=> !EXECUTING && !LEDS.run)
        else $error("running with key off");
    a_stop_dark: assert property (STOP_ERROR [*5] |=> !EXECUTING && !LEDS.run)
        else $error("running with stop error");
    a_stop_flicker: assert property (s_stop_held |-> ##[0:12] (!STOP_ERROR || $changed(LEDS.error)))
        else $error("error lamp steady on stop error");
    a_cont_flag: assert property (s_cont_held |=> DIAGNOSTIC_ERROR_FLAG && SELF_DIAGNOSTIC_ERROR_FLAG)
        else $error("error flags missing");
    a_flags_together: assert property ($rose(DIAGNOSTIC_ERROR_FLAG) |-> $rose(SELF_DIAGNOSTIC_ERROR_FLAG))
        else $error("flags set apart");
    a_boot_dark: assert property (!boot_seen |-> !LEDS.boot)
        else $error("boot lamp without boot");
    a_scan_pulse: assert property (SCAN_START |=> !SCAN_START)
        else $error("scan start longer than a cycle");
endmodule : sleds_checker
bind sleds_top sleds_checker #(.FLICKER_HALF(FLICKER_HALF), .SCAN_UNIT(SCAN_UNIT)) i_checker (
    .CLK(CLK), .NRST(NRST), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .KEY_SWITCH(KEY_SWITCH),
    .STOP_ERROR(STOP_ERROR), .CONT_ERROR(CONT_ERROR), .BOOT_DONE(BOOT_DONE), .LEDS(LEDS),
    .DIAGNOSTIC_ERROR_FLAG(DIAGNOSTIC_ERROR_FLAG), .SELF_DIAGNOSTIC_ERROR_FLAG(SELF_DIAGNOSTIC_ERROR_FLAG),
    .SCAN_START(SCAN_START), .EXECUTING(EXECUTING));

// file: verification/sleds_panel.sv
`timescale 1ns/1ps
module sleds_panel
    import sleds_pkg::*;
(
    // Clock.
    input  wire logic       clk,
    // Requested and reported key position.
    input  wire logic [1:0] key_req,
    output logic      [1:0] key
);
    // A hand-turned key moves between clock edges; it is seen here only after an edge.
    always_ff @(posedge clk) begin
        key <= key_req;
    end
endmodule : sleds_panel

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench
    import sleds_pkg::*;
;
    logic        clk = 1'h0, nrst = 1'h0, hsel = 1'h0, hwrite = 1'h0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0, key_req = 2'h0, key;
    logic [2:0]  hsize = 3'h0;
    logic        pw = 1'h0, stop_err = 1'h0, lcb = 1'h0, boot = 1'h0, sdone = 1'h0, lsb = 1'h0;
    logic [10:1] cerr = 10'h0;
    sleds_led_s  leds;
    logic        diag, sdiag, sstart, mhold, exec;
    int          err_count = 0, checked = 0, cycles = 0, n;
    always #5 clk = ~clk;
    // The short flicker and scan unit keep the run brief; expectations use these values.
    sleds_top #(.FLICKER_HALF(4), .SCAN_UNIT(2)) i_dut (
        .CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .KEY_SWITCH(key), .PROGRAM_WRITTEN(pw), .STOP_ERROR(stop_err), .CONT_ERROR(cerr),
        .LATCH_CLEAR_BUSY(lcb), .BOOT_DONE(boot), .SCAN_DONE(sdone), .LOW_SPEED_BUSY(lsb), .LEDS(leds),
        .DIAGNOSTIC_ERROR_FLAG(diag), .SELF_DIAGNOSTIC_ERROR_FLAG(sdiag), .SCAN_START(sstart),
        .MAIN_HOLD(mhold), .EXECUTING(exec));
    sleds_panel i_panel (.clk(clk), .key_req(key_req), .key(key));
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'h1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'h0, a, 32'h0, r);
        chk(r & m, e);
    endtask : rd
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    // Triggers act on a rising bit, so each pulse is written high and then low again.
    task automatic trig(input logic [31:0] b);
        wr(ADDR_CONTROL, 32'h8 | b);
        wr(ADDR_CONTROL, 32'h8);
    endtask : trig
    task automatic flk(input int b);
        int k;
        k = 0;
        repeat (16) begin
            @(posedge clk);
            k += leds[b];
        end
        chk(32'(k > 0 && k < 16), 32'h1);
    endtask : flk
    task automatic gap(output int k);
        k = 0;
        while (sstart !== 1'h1) @(posedge clk);
        do begin
            @(posedge clk);
            k++;
        end while (sstart !== 1'h1 && k < 200);
    endtask : gap
    task automatic finish_test();
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    initial begin
        cyc(12);
        nrst <= 1'h1;
        rd(ADDR_PRIO_LOW, 32'hffff_ffff, 32'h4321);
        rd(ADDR_PRIO_MID, 32'hffff_ffff, 32'h8765);
        rd(ADDR_PRIO_HIGH, 32'hffff_ffff, 32'h00a9);
        rd(ADDR_CONTROL, 32'hffff_ffff, 32'h8);
        rd(8'h40, 32'hffff_ffff, 32'h0);
        for (int i = 0; i < 4; i++) begin
            key_req <= 2'(i);
            cyc(8);
            chk(leds, 32'(i == 1 || i == 2) << 4);
        end
        key_req <= SLEDS_KEY_RUN;
        stop_err <= 1'h1;
        cyc(30);
        chk(exec, 1'h0);
        stop_err <= 1'h0;
        key_req <= SLEDS_KEY_STOP;
        cyc(8);
        pw <= 1'h1;
        cyc(4);
        pw <= 1'h0;
        key_req <= SLEDS_KEY_RUN;
        cyc(8);
        chk(exec, 1'h0);
        flk(4);
        key_req <= SLEDS_KEY_STOP;
        cyc(8);
        key_req <= SLEDS_KEY_RUN;
        cyc(8);
        chk(leds, 32'h10);
        cerr[6] <= 1'h1;
        cyc(8);
        cerr[6] <= 1'h0;
        chk(leds, 32'h1c);
        rd(ADDR_STATUS, 32'h7800, 32'h3000);
        rd(ADDR_DIAG_CODE, 32'hffff_ffff, 32'h2600);
        wr(ADDR_LED_OFF_SELECT, 32'h10);
        trig(32'h2);
        cyc(6);
        chk(leds, 32'h18);
        trig(32'h4);
        cyc(6);
        chk(leds, 32'h10);
        lcb <= 1'h1;
        cyc(6);
        flk(2);
        lcb <= 1'h0;
        wr(ADDR_PRIO_LOW, 32'h4021);
        cerr[3] <= 1'h1;
        cyc(8);
        cerr[3] <= 1'h0;
        chk(leds.error, 1'h0);
        rd(ADDR_DIAG_CODE, 32'hffff_ffff, 32'h2300);
        trig(32'h4);
        wr(ADDR_PRIO_LOW, 32'h4351);
        wr(ADDR_PRIO_MID, 32'h8762);
        cerr <= 10'h012;
        cyc(8);
        rd(ADDR_STATUS, 32'h7800, 32'h2800);
        wr(ADDR_PRIO_LOW, 32'h4321);
        wr(ADDR_PRIO_MID, 32'h8765);
        cyc(4);
        rd(ADDR_STATUS, 32'h7800, 32'h1000);
        stop_err <= 1'h1;
        cyc(8);
        flk(3);
        stop_err <= 1'h0;
        cerr <= 10'h0;
        trig(32'h4);
        cerr[4] <= 1'h1;
        cyc(5);
        cerr[4] <= 1'h0;
        cyc(5);
        chk(leds.error, 1'h1);
        wr(ADDR_CONTROL, 32'h10);
        rd(ADDR_STATUS, 32'h180, 32'h0);
        chk(leds.error, 1'h0);
        wr(ADDR_ERR_RESET_CODE, 32'h2411);
        trig(32'h1);
        cyc(6);
        chk(leds.error, 1'h0);
        cerr[9] <= 1'h1;
        boot <= 1'h1;
        cyc(8);
        cerr[9] <= 1'h0;
        chk(leds, 32'h13);
        trig(32'h4);
        cyc(6);
        chk(leds, 32'h11);
        wr(ADDR_LED_OFF_SELECT, 32'h100);
        trig(32'h2);
        cyc(6);
        chk(leds, 32'h10);
        sdone <= 1'h1;
        wr(ADDR_CONST_SCAN, 32'h5);
        gap(n);
        gap(n);
        chk(n, 32'd10);
        cyc(7);
        chk(mhold, 1'h1);
        gap(n);
        lsb <= 1'h1;
        fork
            begin
                cyc(25);
                lsb <= 1'h0;
            end
        join_none
        gap(n);
        chk(32'(n > 24), 32'h1);
        sdone <= 1'h0;
        cyc(40);
        sdone <= 1'h1;
        cyc(6);
        rd(ADDR_DIAG_CODE, 32'hffff_ffff, 32'h5010);
        gap(n);
        gap(n);
        chk(32'(n < 10), 32'h1);
        nrst <= 1'h0;
        cyc(3);
        nrst <= 1'h1;
        wr(ADDR_CONST_SCAN, 32'h5);
        wr(ADDR_WATCHDOG, 32'h3);
        cyc(30);
        chk(exec, 1'h0);
        rd(ADDR_STATUS, 32'h200, 32'h200);
        finish_test();
    end
endmodule : testbench
